// File: core/rmpp_consts.svh
// Constants of the reading math post-processor: register offsets, field
// positions, reset values and timing counts.
// Assumes inclusion by bare name from the design module.
`ifndef RMPP_CONSTS_SVH
`define RMPP_CONSTS_SVH

// Register byte offsets on the AXI4-Lite slave.
`define RMPP_OFF_CTRL        8'h00
`define RMPP_OFF_OFFSET      8'h04
`define RMPP_OFF_DBREF       8'h08
`define RMPP_OFF_REFRES      8'h0C
`define RMPP_OFF_PNL_OFFSET  8'h10
`define RMPP_OFF_PNL_DBREF   8'h14
`define RMPP_OFF_STATUS      8'h18
`define RMPP_OFF_MIN         8'h1C
`define RMPP_OFF_MAX         8'h20
`define RMPP_OFF_AVG         8'h24
`define RMPP_OFF_COUNT       8'h28

// Control register field positions.
`define RMPP_CTRL_OP_LSB     0
`define RMPP_CTRL_EN_BIT     3
`define RMPP_CTRL_BEEP_BIT   4
`define RMPP_CTRL_FUNC_LSB   8

// Status register field positions.
`define RMPP_ST_EN_BIT       0
`define RMPP_ST_CONFLICT_BIT 1
`define RMPP_ST_BUSY_BIT     2
`define RMPP_ST_OFFSET_BIT   3
`define RMPP_ST_DBREF_BIT    4

// Reset value and write limits.
`define RMPP_REFRES_RST      32'h0000_0258
`define RMPP_DBREF_LIMIT     32'h0000_4E20
`define RMPP_OFFSET_LIMIT    32'h4786_8C00

// Fixed-point conversion constants (centi-dB).
`define RMPP_CDB_PER_OCT     22'h00012D
`define RMPP_DBM_OFFSET_CDB  32'hFFFF_DCD8

// Averaging divider steps, one per quotient bit.
`define RMPP_DIV_STEPS       6'h30

// AXI responses.
`define RMPP_RESP_OKAY       2'h0
`define RMPP_RESP_SLVERR     2'h2

`endif

// File: core/rmpp_pkg.sv
// Types of the reading math post-processor: operations, functions, sequencer
// states and the packed state record of the datapath.
// Assumes the constants header is on the include path.
package rmpp_pkg;

  // Math operations; the code is the value of the control select field.
  typedef enum logic [2:0] {
    RMPP_OP_NULL,
    RMPP_OP_DB,
    RMPP_OP_DBM,
    RMPP_OP_AVG,
    RMPP_OP_LIMIT
  } rmpp_op_t;

  // Measurement functions; the code is the value of the control func field.
  typedef enum logic [3:0] {
    RMPP_F_DCV, RMPP_F_ACV, RMPP_F_DCI, RMPP_F_ACI, RMPP_F_OHM2, RMPP_F_OHM4,
    RMPP_F_FREQ, RMPP_F_PER, RMPP_F_CONT, RMPP_F_DIODE, RMPP_F_RATIO
  } rmpp_func_t;

  // Reading sequencer states.
  typedef enum logic [1:0] {RMPP_IDLE, RMPP_CALC, RMPP_DIV, RMPP_OUT} rmpp_fsm_t;

  // Whole state of the post-processor.
  typedef struct packed {
    logic               aw_full;
    logic [7:0]         awaddr;
    logic               w_full;
    logic [31:0]        wdata;
    logic [3:0]         wstrb;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               rvalid;
    logic [31:0]        rdata;
    logic [1:0]         rresp;
    logic [2:0]         op;
    logic               en;
    logic               beep_en;
    logic [3:0]         func;
    logic signed [31:0] offset;
    logic               off_set;
    logic signed [31:0] dbref;
    logic               db_set;
    logic [31:0]        refres;
    logic               conflict;
    logic signed [31:0] vmin;
    logic signed [31:0] vmax;
    logic signed [31:0] avg;
    logic [31:0]        count;
    logic signed [47:0] sum;
    rmpp_fsm_t          fsm;
    logic signed [31:0] rdg;
    logic signed [31:0] result;
    logic [32:0]        rem;
    logic [47:0]        dvd;
    logic               avg_neg;
    logic [5:0]         steps;
    logic               extreme;
    logic               beep;
  } rmpp_state_t;

endpackage

// File: core/rmpp_core.sv
// Reading math post-processor: applies the selected math operation other than limit to each
// reading from the measurement core, with an AXI4-Lite register slave.
// Assumes readings are signed microunits, one per handshake, on sys_clk_i.
//
// The AXI4-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "rmpp_consts.svh"

module rmpp_core #(
  parameter logic [31:0] OFFSET_LIMIT = `RMPP_OFFSET_LIMIT  // Largest offset magnitude.
) (
  // Clock and reset.
  input  wire logic                sys_clk_i,
  input  wire logic                rst_i,
  // AXI4-Lite write channels.
  input  wire logic                s_axi_awvalid_i,
  output      logic                s_axi_awready_o,
  input  wire logic [7:0]          s_axi_awaddr_i,
  input  wire logic                s_axi_wvalid_i,
  output      logic                s_axi_wready_o,
  input  wire logic [31:0]         s_axi_wdata_i,
  input  wire logic [3:0]          s_axi_wstrb_i,
  output      logic                s_axi_bvalid_o,
  input  wire logic                s_axi_bready_i,
  output      logic [1:0]          s_axi_bresp_o,
  // AXI4-Lite read channels.
  input  wire logic                s_axi_arvalid_i,
  output      logic                s_axi_arready_o,
  input  wire logic [7:0]          s_axi_araddr_i,
  output      logic                s_axi_rvalid_o,
  input  wire logic                s_axi_rready_i,
  output      logic [31:0]         s_axi_rdata_o,
  output      logic [1:0]          s_axi_rresp_o,
  // Readings from the measurement core.
  input  wire logic                rdg_valid_i,
  output      logic                rdg_ready_o,
  input  wire logic signed [31:0]  rdg_data_i,
  // Processed results.
  output      logic                res_valid_o,
  input  wire logic                res_ready_i,
  output      logic signed [31:0]  res_data_o,
  // Indications.
  output      logic                extreme_o,
  output      logic                beep_o
);
  import rmpp_pkg::*;

  rmpp_pkg::rmpp_state_t s;       // Registered state.
  rmpp_pkg::rmpp_state_t n;       // Next state.
  logic                  wr_go;   // Both write halves held and no response pending.
  logic                  rd_go;   // Read address taken this cycle.

  // Tells whether an operation is allowed with a measurement function.
  function automatic logic rmpp_allowed(input logic [2:0] op, input logic [3:0] f);
    logic ok;
    ok = 1'b0;
    case (op)
      3'(RMPP_OP_NULL): ok = (f <= 4'(RMPP_F_PER));
      3'(RMPP_OP_AVG), 3'(RMPP_OP_LIMIT):
        ok = (f <= 4'(RMPP_F_PER)) || (f == 4'(RMPP_F_RATIO));
      3'(RMPP_OP_DB), 3'(RMPP_OP_DBM):
        ok = (f == 4'(RMPP_F_DCV)) || (f == 4'(RMPP_F_ACV));
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // Merges written bytes over an old value under the byte strobes.
  function automatic logic [31:0] rmpp_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] be);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        m[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return m;
  endfunction

  // Returns 1000 times log10 of a value, by a piecewise linear log2.
  function automatic logic signed [31:0] rmpp_cdb10(input logic [31:0] v);
    logic [4:0]  k;
    logic [31:0] sh;
    logic [12:0] lg;
    k  = 5'h00;
    for (int i = 0; i < 32; i++)
    begin
      if (v[i])
      begin
        k = 5'(i);
      end
    end
    sh = v << (5'h1F - k);
    lg = {k, sh[30:23]};
    return signed'(32'((22'(lg) * `RMPP_CDB_PER_OCT) >> 8));
  endfunction

  // Converts a reading to dBm in centi-dB against the reference resistance.
  function automatic logic signed [31:0] rmpp_dbm(input logic signed [31:0] r,
                                                  input logic [31:0] res);
    logic [31:0] mag;
    mag = r[31] ? 32'(-r) : 32'(r);
    return 32'(2 * rmpp_cdb10(mag) - rmpp_cdb10(res)
               + signed'(`RMPP_DBM_OFFSET_CDB));
  endfunction

  // Checks a signed value against a magnitude bound.
  function automatic logic rmpp_in_range(input logic signed [31:0] v,
                                         input logic [31:0] lim);
    return (v <= signed'(lim)) && (v >= -signed'(lim));
  endfunction

  // Handshake outputs and register-sourced data.
  assign s_axi_awready_o = !s.aw_full && !s.bvalid;
  assign s_axi_wready_o  = !s.w_full && !s.bvalid;
  assign s_axi_bvalid_o  = s.bvalid;
  assign s_axi_bresp_o   = s.bresp;
  assign s_axi_arready_o = !s.rvalid;
  assign s_axi_rvalid_o  = s.rvalid;
  assign s_axi_rdata_o   = s.rdata;
  assign s_axi_rresp_o   = s.rresp;
  assign rdg_ready_o     = (s.fsm == RMPP_IDLE);
  assign res_valid_o     = (s.fsm == RMPP_OUT);
  assign res_data_o      = s.result;
  assign extreme_o       = s.extreme;
  assign beep_o          = s.beep;
  assign wr_go           = s.aw_full && s.w_full && !s.bvalid;
  assign rd_go           = s_axi_arvalid_i && !s.rvalid;

  // Next-state logic: bus slave, configuration and the reading sequencer.
  always_comb
  begin
    logic [31:0]        v;
    logic [2:0]         nop;
    logic               nen;
    logic [3:0]         nfunc;
    logic signed [31:0] d;
    logic [32:0]        t;
    v     = 32'h0000_0000;
    nop   = 3'h0;
    nen   = 1'b0;
    nfunc = 4'h0;
    d     = 32'sh0000_0000;
    t     = 33'h0_0000_0000;
    n     = s;
    n.extreme = 1'b0;
    n.beep    = 1'b0;
    // Write address and data are latched independently, in either order.
    if (s_axi_awvalid_i && s_axi_awready_o)
    begin
      n.aw_full = 1'b1;
      n.awaddr  = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o)
    begin
      n.w_full = 1'b1;
      n.wdata  = s_axi_wdata_i;
      n.wstrb  = s_axi_wstrb_i;
    end
    if (s.bvalid && s_axi_bready_i)
    begin
      n.bvalid = 1'b0;
    end
    // A complete write updates the addressed register and raises the response.
    if (wr_go)
    begin
      n.aw_full = 1'b0;
      n.w_full  = 1'b0;
      n.bvalid  = 1'b1;
      n.bresp   = `RMPP_RESP_OKAY;
      case (s.awaddr)
        `RMPP_OFF_CTRL:
        begin
          v     = rmpp_merge({20'h00000, s.func, 3'h0, s.beep_en, s.en, s.op},
                             s.wdata, s.wstrb);
          nop   = v[`RMPP_CTRL_OP_LSB +: 3];
          nen   = v[`RMPP_CTRL_EN_BIT];
          nfunc = v[`RMPP_CTRL_FUNC_LSB +: 4];
          n.beep_en = v[`RMPP_CTRL_BEEP_BIT];
          n.op      = nop;
          n.func    = nfunc;
          if (nfunc != s.func)
          begin
            // A function change drops math and forgets both references.
            n.en      = 1'b0;
            n.offset  = 32'sh0000_0000;
            n.off_set = 1'b0;
            n.dbref   = 32'sh0000_0000;
            n.db_set  = 1'b0;
          end
          else if (nen && !rmpp_allowed(nop, s.func))
          begin
            n.en = 1'b0;
            if (s.en && rmpp_allowed(s.op, s.func))
            begin
              n.conflict = 1'b1;
            end
          end
          else
          begin
            n.en = nen;
            if (nen && nop == 3'(RMPP_OP_AVG) && !(s.en && s.op == 3'(RMPP_OP_AVG)))
            begin
              // Min-max starts from an empty history.
              n.vmin  = 32'sh0000_0000;
              n.vmax  = 32'sh0000_0000;
              n.avg   = 32'sh0000_0000;
              n.sum   = 48'sh0000_0000_0000;
              n.count = 32'h0000_0000;
            end
          end
        end
        `RMPP_OFF_OFFSET:
        begin
          v = rmpp_merge(s.offset, s.wdata, s.wstrb);
          // Remote offset is only stored while math is on and in bounds.
          if (s.en && rmpp_in_range(v, OFFSET_LIMIT))
          begin
            n.offset  = v;
            n.off_set = 1'b1;
          end
          else
          begin
            n.bresp = `RMPP_RESP_SLVERR;
          end
        end
        `RMPP_OFF_DBREF:
        begin
          v = rmpp_merge(s.dbref, s.wdata, s.wstrb);
          if (s.en && rmpp_in_range(v, `RMPP_DBREF_LIMIT))
          begin
            n.dbref  = v;
            n.db_set = 1'b1;
          end
          else
          begin
            n.bresp = `RMPP_RESP_SLVERR;
          end
        end
        `RMPP_OFF_REFRES:
        begin
          // The stored decibel reference is left as it is.
          n.refres = rmpp_merge(s.refres, s.wdata, s.wstrb);
        end
        `RMPP_OFF_PNL_OFFSET:
        begin
          v = rmpp_merge(s.offset, s.wdata, s.wstrb);
          if (rmpp_in_range(v, OFFSET_LIMIT))
          begin
            n.offset  = v;
            n.off_set = 1'b1;
            n.op      = 3'(RMPP_OP_NULL);
            n.en      = rmpp_allowed(3'(RMPP_OP_NULL), s.func);
          end
          else
          begin
            n.bresp = `RMPP_RESP_SLVERR;
          end
        end
        `RMPP_OFF_PNL_DBREF:
        begin
          v = rmpp_merge(s.dbref, s.wdata, s.wstrb);
          if (rmpp_in_range(v, `RMPP_DBREF_LIMIT))
          begin
            n.dbref  = v;
            n.db_set = 1'b1;
            n.op     = 3'(RMPP_OP_DB);
            n.en     = rmpp_allowed(3'(RMPP_OP_DB), s.func);
          end
          else
          begin
            n.bresp = `RMPP_RESP_SLVERR;
          end
        end
        `RMPP_OFF_STATUS:
        begin
          // Writing one clears the conflict flag.
          if (s.wstrb[0] && s.wdata[`RMPP_ST_CONFLICT_BIT])
          begin
            n.conflict = 1'b0;
          end
        end
        default:
        begin
          n.bresp = `RMPP_RESP_SLVERR;
        end
      endcase
    end
    // Reads are answered from the state one edge after the address is taken.
    if (s.rvalid && s_axi_rready_i)
    begin
      n.rvalid = 1'b0;
    end
    if (rd_go)
    begin
      n.rvalid = 1'b1;
      n.rresp  = `RMPP_RESP_OKAY;
      case (s_axi_araddr_i)
        `RMPP_OFF_CTRL:
          n.rdata = {20'h00000, s.func, 3'h0, s.beep_en, s.en, s.op};
        `RMPP_OFF_OFFSET, `RMPP_OFF_PNL_OFFSET: n.rdata = s.offset;
        `RMPP_OFF_DBREF, `RMPP_OFF_PNL_DBREF:   n.rdata = s.dbref;
        `RMPP_OFF_REFRES: n.rdata = s.refres;
        `RMPP_OFF_STATUS:
          n.rdata = {27'h0000000, s.db_set, s.off_set, (s.fsm != RMPP_IDLE), s.conflict, s.en};
        `RMPP_OFF_MIN:    n.rdata = s.vmin;
        `RMPP_OFF_MAX:    n.rdata = s.vmax;
        `RMPP_OFF_AVG:    n.rdata = s.avg;
        `RMPP_OFF_COUNT:  n.rdata = s.count;
        default:
        begin
          n.rdata = 32'h0000_0000;
          n.rresp = `RMPP_RESP_SLVERR;
        end
      endcase
    end
    // Reading sequencer: take, compute, optionally average, then hand over.
    unique case (s.fsm)
      RMPP_IDLE:
      begin
        if (rdg_valid_i)
        begin
          n.rdg = rdg_data_i;
          n.fsm = RMPP_CALC;
        end
      end
      RMPP_CALC:
      begin
        n.result = s.rdg;
        n.fsm    = RMPP_OUT;
        if (s.en)
        begin
          case (s.op)
            3'(RMPP_OP_NULL):
            begin
              d = s.off_set ? s.offset : s.rdg;
              // Capture only when nothing is held, so a write in this cycle wins.
              if (!n.off_set)
              begin
                n.offset  = s.rdg;
                n.off_set = 1'b1;
              end
              n.result  = 32'(s.rdg - d);
            end
            3'(RMPP_OP_DB):
            begin
              d = s.db_set ? s.dbref : rmpp_dbm(s.rdg, s.refres);
              // Capture only when nothing is held, so a write in this cycle wins.
              if (!n.db_set)
              begin
                n.dbref  = d;
                n.db_set = 1'b1;
              end
              n.result = 32'(rmpp_dbm(s.rdg, s.refres) - d);
            end
            3'(RMPP_OP_DBM):
              n.result = rmpp_dbm(s.rdg, s.refres);
            3'(RMPP_OP_AVG):
            begin
              if (s.count == 32'h0000_0000)
              begin
                n.vmin    = s.rdg;
                n.vmax    = s.rdg;
                n.extreme = 1'b1;
              end
              else
              begin
                if (s.rdg < s.vmin)
                begin
                  n.vmin    = s.rdg;
                  n.extreme = 1'b1;
                end
                if (s.rdg > s.vmax)
                begin
                  n.vmax    = s.rdg;
                  n.extreme = 1'b1;
                end
              end
              n.beep    = n.extreme && s.beep_en;
              n.count   = s.count + 32'h0000_0001;
              n.sum     = s.sum + 48'(s.rdg);
              n.avg_neg = n.sum[47];
              n.dvd     = n.sum[47] ? 48'(-n.sum) : 48'(n.sum);
              n.rem     = 33'h0_0000_0000;
              n.steps   = `RMPP_DIV_STEPS;
              n.fsm     = RMPP_DIV;
            end
            default: n.result = s.rdg;
          endcase
        end
      end
      RMPP_DIV:
      begin
        // Restoring division of the running sum by the count.
        t = {s.rem[31:0], s.dvd[47]};
        if (t >= {1'b0, s.count})
        begin
          n.rem = t - {1'b0, s.count};
          n.dvd = {s.dvd[46:0], 1'b1};
        end
        else
        begin
          n.rem = t;
          n.dvd = {s.dvd[46:0], 1'b0};
        end
        n.steps = s.steps - 6'h01;
        if (s.steps == 6'h01)
        begin
          n.avg = s.avg_neg ? 32'(-n.dvd[31:0]) : n.dvd[31:0];
          n.fsm = RMPP_OUT;
        end
      end
      RMPP_OUT:
      begin
        if (res_ready_i)
        begin
          n.fsm = RMPP_IDLE;
        end
      end
    endcase
    // A function change that meets a capture still forgets both references.
    if (n.func != s.func)
    begin
      n.offset  = 32'sh0000_0000;
      n.off_set = 1'b0;
      n.dbref   = 32'sh0000_0000;
      n.db_set  = 1'b0;
    end
  end

  // State register; reset stands for power-on or a remote reset.
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s        <= '0;
      s.op     <= 3'(RMPP_OP_NULL);
      s.refres <= `RMPP_REFRES_RST;
      s.fsm    <= RMPP_IDLE;
    end
    else
    begin
      s <= n;
    end
  end

  // Reading taken moves to compute next edge.
  rdg_take_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    rdg_valid_i && rdg_ready_o |=> s.fsm == RMPP_CALC && s.rdg == $past(rdg_data_i))
    else $error("reading not taken");
  // Offered result holds until taken.
  res_hold_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    res_valid_o && !res_ready_i |=> res_valid_o && $stable(res_data_o))
    else $error("result dropped before taken");
  // Active math is always a permitted pair.
  math_legal_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s.en |-> rmpp_allowed(s.op, s.func))
    else $error("illegal math active");
  // Function change turns math off and clears references.
  func_clear_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $changed(s.func) |-> !s.en && !s.off_set && !s.db_set && s.offset == 32'sh0000_0000)
    else $error("function change kept math state");
  // Conflict only raised out of active math.
  conflict_src_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $rose(s.conflict) |-> $past(s.en) && !s.en)
    else $error("conflict without active math");
  // Null result equals reading minus offset.
  null_calc_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s.fsm == RMPP_CALC && s.en && s.op == 3'(RMPP_OP_NULL)
    |=> s.result == 32'($past(s.rdg)
                        - ($past(s.off_set) ? $past(s.offset) : $past(s.rdg))))
    else $error("null result wrong");
  // First tracked reading loads both extremes.
  first_load_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s.fsm == RMPP_CALC && s.en && s.op == 3'(RMPP_OP_AVG) && s.count == 32'h0000_0000
    |=> s.vmin == $past(s.rdg) && s.vmax == $past(s.rdg) && extreme_o)
    else $error("first reading not loaded");
  // Extremes stay ordered while tracking.
  min_max_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s.count != 32'h0000_0000 |-> s.vmin <= s.vmax)
    else $error("minimum above maximum");
  // Beep follows an extreme only with the beeper on.
  beep_gate_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    beep_o |-> extreme_o && $past(s.beep_en))
    else $error("beep without extreme");
  // Averaging finishes in a bounded time.
  div_done_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s.fsm == RMPP_CALC && s.en && s.op == 3'(RMPP_OP_AVG) |-> ##49 s.fsm == RMPP_OUT)
    else $error("average not finished");

endmodule  // rmpp_core

// File: dv/rmpp_rdg_src.sv
// Model of the measurement core that feeds readings to the post-processor.
// Assumes a free-running clock and one send call at a time.
`timescale 1ns/1ps
module rmpp_rdg_src (
  // Clock.
  input  wire logic               clk_i,
  // Reading handshake.
  output      logic               valid_o,
  input  wire logic               ready_i,
  output      logic signed [31:0] data_o
);
  initial
  begin
    valid_o = 1'b0;
    data_o  = 32'h0;
  end
  // Offers one reading and holds it until the edge that takes it.
  task automatic send(input logic signed [31:0] d);
    @(posedge clk_i);
    valid_o <= 1'b1;
    data_o  <= d;
    do @(negedge clk_i); while (ready_i !== 1'b1);
    @(posedge clk_i);
    valid_o <= 1'b0;
    data_o  <= ~d; // Released data must not look like the old reading.
  endtask
endmodule // rmpp_rdg_src

// File: dv/reading_math_postprocessor_test.sv
// Testbench of the post-processor: AXI4-Lite register calls and readings.
// Assumes the reading source model and the core sit beside it.
`timescale 1ns/1ps
module reading_math_postprocessor_test;
  logic sys_clk_i = 0, rst_i = 1, res_ready_i = 1;
  logic s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0;
  logic s_axi_arvalid_i = 0, s_axi_rready_i = 0;
  logic [7:0] s_axi_awaddr_i = 0, s_axi_araddr_i = 0;
  logic [31:0] s_axi_wdata_i = 0, s_axi_rdata_o;
  logic [3:0] s_axi_wstrb_i = 4'hF;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic rdg_valid_i, rdg_ready_o, res_valid_o, extreme_o, beep_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, r;
  logic signed [31:0] rdg_data_i, res_data_o;
  logic [31:0] d;
  int n_mismatch = 0, total_checks = 0, cyc = 0, n_ext = 0, n_beep = 0, e0;
  logic [10:0] ok [5] = '{11'h0FF, 11'h003, 11'h003, 11'h4FF, 11'h4FF};
  rmpp_core uut (.sys_clk_i, .rst_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_awaddr_i,
    .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_bvalid_o,
    .s_axi_bready_i, .s_axi_bresp_o, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_araddr_i,
    .s_axi_rvalid_o, .s_axi_rready_i, .s_axi_rdata_o, .s_axi_rresp_o, .rdg_valid_i,
    .rdg_ready_o, .rdg_data_i, .res_valid_o, .res_ready_i, .res_data_o, .extreme_o, .beep_o);
  rmpp_rdg_src src (.clk_i(sys_clk_i), .valid_o(rdg_valid_i), .ready_i(rdg_ready_o),
    .data_o(rdg_data_i));
  initial
  begin
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  // Counts indication pulses away from the edge that sets them.
  always @(negedge sys_clk_i)
  begin
    n_ext  += (extreme_o === 1'b1);
    n_beep += (beep_o === 1'b1);
  end
  // Cuts a hang short.
  always @(posedge sys_clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // One AXI4-Lite write; address and data are released as each is taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ta, tw;
    ta = 0;
    tw = 0;
    @(posedge sys_clk_i);
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 3'h7;
    s_axi_awaddr_i <= a;
    s_axi_wdata_i  <= v;
    while (!(ta && tw))
    begin
      @(negedge sys_clk_i);
      ta |= s_axi_awvalid_i && s_axi_awready_o;
      tw |= s_axi_wvalid_i && s_axi_wready_o;
      @(posedge sys_clk_i);
      if (ta) s_axi_awvalid_i <= 0;
      if (tw) s_axi_wvalid_i <= 0;
    end
    do @(negedge sys_clk_i); while (s_axi_bvalid_o !== 1'b1);
    r = s_axi_bresp_o;
    @(posedge sys_clk_i);
    s_axi_bready_i <= 0;
  endtask
  // One AXI4-Lite read.
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk_i);
    {s_axi_arvalid_i, s_axi_rready_i} <= 2'h3;
    s_axi_araddr_i <= a;
    do @(negedge sys_clk_i); while (s_axi_arready_o !== 1'b1);
    @(posedge sys_clk_i);
    s_axi_arvalid_i <= 0;
    do @(negedge sys_clk_i); while (s_axi_rvalid_o !== 1'b1);
    {d, r} = {s_axi_rdata_o, s_axi_rresp_o};
    @(posedge sys_clk_i);
    s_axi_rready_i <= 0;
  endtask
  // Sends one reading and returns its result in d.
  task automatic rdg(input logic [31:0] v);
    src.send(v);
    do @(negedge sys_clk_i); while (res_valid_o !== 1'b1);
    d = res_data_o;
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge sys_clk_i);
    rst_i <= 0;
    rd(8'h00); chk(d, 32'h0);
    rd(8'h0C); chk(d, 32'h258);
    rd(8'h40); chk(r, 2'h2);
    // Every operation against every function, changing function first.
    for (int f = 0; f < 11; f++)
      for (int o = 0; o < 5; o++)
      begin
        wr(8'h00, 32'(f) << 8);
        wr(8'h00, (32'(f) << 8) | 32'h8 | 32'(o));
        rd(8'h18); chk(d[0], ok[o][f]);
      end
    wr(8'h18, 32'h2);
    wr(8'h00, 32'hA0B);
    wr(8'h00, 32'hA08);
    rd(8'h18); chk(d[1:0], 2'h2);
    wr(8'h00, 32'h0);
    wr(8'h00, 32'h8);
    rdg(32'h3E8); chk(d, 32'h0);
    rdg(32'h5DC); chk(d, 32'h1F4);
    wr(8'h04, 32'h12C); chk(r, 2'h0);
    rdg(32'h3E8); chk(d, 32'h2BC);
    wr(8'h00, 32'h108);
    rd(8'h04); chk(d, 32'h0);
    rd(8'h18); chk(d[0], 1'b0);
    wr(8'h04, 32'h5); chk(r, 2'h2);
    wr(8'h00, 32'h11B);
    rdg(32'h5);
    e0 = n_ext;
    rdg(32'h2);
    rdg(32'h9); chk(n_ext, e0 + 2);
    rdg(32'h8); chk(n_ext, e0 + 2);
    chk(n_beep, n_ext);
    rd(8'h1C); chk(d, 32'h2);
    rd(8'h20); chk(d, 32'h9);
    rd(8'h24); chk(d, 32'h6);
    rd(8'h28); chk(d, 32'h4);
    wr(8'h00, 32'h113);
    wr(8'h00, 32'h11B);
    rd(8'h28); chk(d, 32'h0);
    wr(8'h00, 32'h109);
    rdg(32'hF4240); chk(d, 32'h0);
    wr(8'h08, 32'h4E21); chk(r, 2'h2);
    // Math off passes readings; a stalled result stands and blocks new readings.
    wr(8'h00, 32'h101);
    res_ready_i <= 1'b0;
    rdg(32'h7);
    repeat (3) @(negedge sys_clk_i);
    chk(res_data_o, 32'h7);
    chk(res_valid_o, 1'b1);
    chk(rdg_ready_o, 1'b0);
    @(posedge sys_clk_i);
    res_ready_i <= 1'b1;
    // A reset mid-run clears the control register and the captured reference.
    @(posedge sys_clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rd(8'h00);
    chk(d, 32'h0);
    rd(8'h08);
    chk(d, 32'h0);
    // Panel offset entry selects null, enables it and is bounded.
    wr(8'h10, 32'h64);
    chk(r, 2'h0);
    rd(8'h18);
    chk(d[0], 1'b1);
    rdg(32'h1F4);
    chk(d, 32'h190);
    wr(8'h10, 32'h4786_8C01);
    chk(r, 2'h2);
    complete_run();
  end
endmodule // reading_math_postprocessor_test
